// ---- rtl/ups_regs.vh ----
`ifndef UPS_REGS_VH
`define UPS_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UPS_CMP_STATUS_ADDR 8'h13
`define UPS_EVT_LATCH_ADDR 8'h14
`define UPS_LINE_DEBUG_ADDR 8'h15
`define UPS_SCRATCH_ADDR 8'h16
`define UPS_SCRATCH_LAST 8'h18
`define UPS_EXT_SELECT_ADDR 6'h2f
`define UPS_POWER_CTL_ADDR 8'h3d
`define UPS_POWER_CTL_LAST 8'h3f
`define UPS_IMM_SPACE_END 8'h40

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define UPS_SCRATCH_RST 8'h00
`define UPS_POWER_CTL_RST 8'h00
`define UPS_PWR_PIN_SEL_BIT 0
`define UPS_PWR_BSV_RISE_BIT 2
`define UPS_PWR_BSV_FALL_BIT 3
`define UPS_RXCMD_ALT_BIT 7

// ----------------------------------------
// Link command codes
// ----------------------------------------
`define UPS_CMD_WRITE 2'b10
`define UPS_CMD_READ 2'b11

`endif

// ---- rtl/ups_status_power.v ----
`timescale 1ns/1ns
`default_nettype none
`include "ups_regs.vh"

module ups_status_power #(
  parameter SYNC_W = 18
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire ulpi_clk_i,
  input wire [7:0] ulpi_data_i,
  input wire ulpi_stp_i,
  input wire session_end_flag_i,
  input wire session_valid_flag_i,
  input wire bus_voltage_ok_flag_i,
  input wire host_unplug_detect_i,
  input wire session_ok_signal_i,
  input wire line_level_bit0_i,
  input wire line_level_bit1_i,
  input wire power_switch_low_i,
  input wire [3:0] rise_en_i,
  input wire [3:0] fall_en_i,
  input wire low_power_i,
  input wire vbus_drive_req_i,
  output reg [7:0] ulpi_data_o,
  output reg ulpi_data_oe_b_o,
  output reg ulpi_dir_o,
  output reg ulpi_nxt_o,
  output reg power_switch_low_o,
  output reg power_switch_low_oe_b_o,
  output reg pin_reset_req_o
);

  // ----------------------------------------
  // Sync vector layout
  // ----------------------------------------
  localparam P_HD = 0;
  localparam P_VBV = 1;
  localparam P_SV = 2;
  localparam P_SE = 3;
  localparam P_BSV = 4;
  localparam P_LS0 = 5;
  localparam P_LS1 = 6;
  localparam P_PIN = 7;
  localparam P_CLK = 8;
  localparam P_STP = 9;
  localparam P_DAT = 10;
  // Pin idles high, so its stage starts high: no reset request right after reset
  localparam [SYNC_W-1:0] SYNC_RST = {{(SYNC_W-1){1'b0}}, 1'b1} << P_PIN;

  // ----------------------------------------
  // Link state machine codes
  // ----------------------------------------
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_EXT = 9'h002;
  localparam [8:0] S_WR_DATA = 9'h004;
  localparam [8:0] S_WR_STP = 9'h008;
  localparam [8:0] S_RD_TURN = 9'h010;
  localparam [8:0] S_RD_DATA = 9'h020;
  localparam [8:0] S_RD_END = 9'h040;
  localparam [8:0] S_RX_DATA = 9'h080;
  localparam [8:0] S_RX_END = 9'h100;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Write, set and clear at three consecutive addresses
  function [7:0] rwsc_upd;
    input [7:0] base;
    input [7:0] addr;
    input [7:0] d;
    input [7:0] old;
    begin
      if (addr == base) begin
        rwsc_upd = d;
      end else if (addr == base + 8'h01) begin
        rwsc_upd = old | d;
      end else if (addr == base + 8'h02) begin
        rwsc_upd = old & ~d;
      end else begin
        rwsc_upd = old;
      end
    end
  endfunction

  function [7:0] rd_value;
    input [7:0] addr;
    input [3:0] cmp;
    input [3:0] lat;
    input [1:0] ls;
    input [7:0] scr;
    input [7:0] pwr;
    begin
      rd_value = 8'h00;
      if (addr == `UPS_CMP_STATUS_ADDR) begin
        rd_value = {4'h0, cmp};
      end
      if (addr == `UPS_EVT_LATCH_ADDR) begin
        rd_value = {4'h0, lat};
      end
      if (addr == `UPS_LINE_DEBUG_ADDR) begin
        rd_value = {6'h00, ls};
      end
      if (addr >= `UPS_SCRATCH_ADDR && addr <= `UPS_SCRATCH_LAST) begin
        rd_value = scr;
      end
      if (addr >= `UPS_POWER_CTL_ADDR && addr <= `UPS_POWER_CTL_LAST) begin
        rd_value = pwr;
      end
    end
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  reg [SYNC_W-1:0] sync_a_r;
  reg [SYNC_W-1:0] sync_b_r;
  reg [SYNC_W-1:0] sync_c_r;
  reg [SYNC_W-1:0] filt_r;
  reg [SYNC_W-1:0] filt_q_r;
  wire [SYNC_W-1:0] raw_in;
  wire [SYNC_W-1:0] agree;
  wire [SYNC_W-1:0] filt_nxt;

  assign raw_in = {ulpi_data_i, ulpi_stp_i, ulpi_clk_i, power_switch_low_i,
                   line_level_bit1_i, line_level_bit0_i, session_ok_signal_i,
                   session_end_flag_i, session_valid_flag_i, bus_voltage_ok_flag_i,
                   host_unplug_detect_i};
  assign agree = ~(sync_b_r ^ sync_c_r);
  // A bit moves only once the second and third stage agree
  assign filt_nxt = (sync_c_r & agree) | (filt_r & ~agree);

  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      sync_a_r <= SYNC_RST;
      sync_b_r <= SYNC_RST;
      sync_c_r <= SYNC_RST;
      filt_r <= SYNC_RST;
      filt_q_r <= SYNC_RST;
    end else begin
      sync_a_r <= raw_in;
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      filt_r <= filt_nxt;
      filt_q_r <= filt_r;
    end
  end

  wire [3:0] cmp_now = filt_r[P_SE:P_HD];
  wire [3:0] cmp_old = filt_q_r[P_SE:P_HD];
  wire [1:0] line_now = filt_r[P_LS1:P_LS0];
  wire [1:0] line_old = filt_q_r[P_LS1:P_LS0];
  wire bsv_now = filt_r[P_BSV];
  wire bsv_old = filt_q_r[P_BSV];
  // Link clock edge; data taken one cycle earlier so it predates the edge
  wire tick = filt_r[P_CLK] & ~filt_q_r[P_CLK];
  wire [7:0] lnk_data = filt_q_r[P_DAT+7:P_DAT];
  wire lnk_stp = filt_q_r[P_STP];

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [3:0] latch_r;
  reg [3:0] latch_nxt;
  reg [7:0] scratch_r;
  reg [7:0] power_r;
  reg [8:0] state_r;
  reg [7:0] addr_r;
  reg is_read_r;
  reg rx_pend_r;
  reg alt_pend_r;

  wire [3:0] evt_hit = (cmp_now & ~cmp_old & rise_en_i) | (~cmp_now & cmp_old & fall_en_i);
  wire alt_fall = power_r[`UPS_PWR_BSV_FALL_BIT] & bsv_old & ~bsv_now;
  wire alt_rise = power_r[`UPS_PWR_BSV_RISE_BIT] & ~bsv_old & bsv_now;
  wire rx_evt = (|evt_hit) | (line_now != line_old);
  wire rd_latch = tick && state_r == S_RD_DATA && addr_r == `UPS_EVT_LATCH_ADDR;
  // Pending flags drop only once the byte is composed, so the alternate bit survives
  wire rx_sent = tick && state_r == S_RX_DATA;
  wire cmd_seen = lnk_data[7:6] == `UPS_CMD_WRITE || lnk_data[7:6] == `UPS_CMD_READ;

  // ----------------------------------------
  // Event latch
  // ----------------------------------------
  always @* begin
    latch_nxt = latch_r;
    if (rd_latch || low_power_i) begin
      latch_nxt = 4'h0;
    end
    // Set wins over a same-cycle clear
    latch_nxt = latch_nxt | evt_hit;
  end

  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      latch_r <= 4'h0;
      rx_pend_r <= 1'b0;
      alt_pend_r <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      // Enabled comparator edges and any line-state change also queued as RXCMD
      rx_pend_r <= rx_evt | (rx_pend_r & ~rx_sent);
      alt_pend_r <= alt_fall | alt_rise | (alt_pend_r & ~rx_sent);
    end
  end

  // ----------------------------------------
  // Link register access
  // ----------------------------------------
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      state_r <= S_IDLE;
      addr_r <= 8'h00;
      is_read_r <= 1'b0;
      scratch_r <= `UPS_SCRATCH_RST;
      power_r <= `UPS_POWER_CTL_RST;
      ulpi_data_o <= 8'h00;
      ulpi_data_oe_b_o <= 1'b1;
      ulpi_dir_o <= 1'b0;
      ulpi_nxt_o <= 1'b0;
    end else if (tick) begin
      case (state_r)
        S_IDLE: begin
          if (cmd_seen) begin
            ulpi_nxt_o <= 1'b1;
            addr_r <= {2'b00, lnk_data[5:0]};
            is_read_r <= lnk_data[6];
            // 2Fh only selects the extended space
            if (lnk_data[5:0] == `UPS_EXT_SELECT_ADDR) begin
              state_r <= S_EXT;
            end else if (lnk_data[6]) begin
              state_r <= S_RD_TURN;
            end else begin
              state_r <= S_WR_DATA;
            end
          end else if (rx_pend_r || alt_pend_r) begin
            ulpi_dir_o <= 1'b1;
            state_r <= S_RX_DATA;
          end
        end
        S_EXT: begin
          // Low extended addresses alias immediate ones
          addr_r <= lnk_data;
          state_r <= is_read_r ? S_RD_TURN : S_WR_DATA;
        end
        S_WR_DATA: begin
          ulpi_nxt_o <= 1'b0;
          scratch_r <= rwsc_upd(`UPS_SCRATCH_ADDR, addr_r, lnk_data, scratch_r);
          power_r <= rwsc_upd(`UPS_POWER_CTL_ADDR, addr_r, lnk_data, power_r);
          state_r <= S_WR_STP;
        end
        S_WR_STP: begin
          if (lnk_stp) begin
            state_r <= S_IDLE;
          end
        end
        S_RD_TURN: begin
          ulpi_nxt_o <= 1'b0;
          ulpi_dir_o <= 1'b1;
          state_r <= S_RD_DATA;
        end
        S_RD_DATA: begin
          ulpi_data_oe_b_o <= 1'b0;
          // Beyond the immediate space reads zero
          if (addr_r < `UPS_IMM_SPACE_END) begin
            ulpi_data_o <= rd_value(addr_r, cmp_now, latch_r, line_now, scratch_r, power_r);
          end else begin
            ulpi_data_o <= 8'h00;
          end
          state_r <= S_RD_END;
        end
        S_RX_DATA: begin
          ulpi_data_oe_b_o <= 1'b0;
          ulpi_data_o <= {alt_pend_r, 1'b0, 2'b00, cmp_now[P_VBV], cmp_now[P_SV], line_now};
          state_r <= S_RX_END;
        end
        S_RD_END, S_RX_END: begin
          ulpi_dir_o <= 1'b0;
          ulpi_data_oe_b_o <= 1'b1;
          ulpi_data_o <= 8'h00;
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
          ulpi_nxt_o <= 1'b0;
          ulpi_dir_o <= 1'b0;
          ulpi_data_oe_b_o <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Shared reset / power switch pin
  // ----------------------------------------
  // Open drain: only ever pulls low, so a ganged wire needs no arbitration
  always @(posedge ref_clk_i) begin
    if (!rst_b_i) begin
      power_switch_low_o <= 1'b0;
      power_switch_low_oe_b_o <= 1'b1;
      pin_reset_req_o <= 1'b0;
    end else begin
      power_switch_low_o <= 1'b0;
      // Pin role follows power bit 0
      if (power_r[`UPS_PWR_PIN_SEL_BIT]) begin
        power_switch_low_oe_b_o <= ~vbus_drive_req_i;
        pin_reset_req_o <= 1'b0;
      end else begin
        power_switch_low_oe_b_o <= 1'b1;
        pin_reset_req_o <= ~filt_r[P_PIN];
      end
    end
  end

endmodule // ups_status_power

`default_nettype wire

// ---- verification/ups_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module ups_monitor #(
  parameter SYNC_W = 18
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire vbus_drive_req_i,
  input wire ulpi_data_oe_b_o,
  input wire ulpi_dir_o,
  input wire ulpi_nxt_o,
  input wire power_switch_low_o,
  input wire power_switch_low_oe_b_o,
  input wire pin_reset_req_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----------------------------------------
  // Pin and bus ownership
  // ----------------------------------------
  AST_PSW_OPEN: assert property (!power_switch_low_o)
    else $error("switch pin driven high");
  AST_RST_ROLE: assert property (pin_reset_req_o |-> power_switch_low_oe_b_o)
    else $error("pin driven in reset role");
  AST_PSW_CAUSE: assert property (!power_switch_low_oe_b_o |-> $past(vbus_drive_req_i))
    else $error("pin pulled without request");
  AST_OE_DIR: assert property (!ulpi_data_oe_b_o |-> ulpi_dir_o)
    else $error("data driven without bus");
  AST_NXT_DIR: assert property (!(ulpi_nxt_o && ulpi_dir_o))
    else $error("nxt while device owns bus");
  AST_TURN: assert property ($rose(ulpi_dir_o) |-> ulpi_data_oe_b_o)
    else $error("no turnaround cycle");
  AST_DIR_DATA: assert property ($rose(ulpi_dir_o) |-> ##[6:10] $fell(ulpi_data_oe_b_o))
    else $error("data late after dir");
  AST_DATA_END: assert property (
      $fell(ulpi_data_oe_b_o) |-> ##[6:10] ($rose(ulpi_data_oe_b_o) && !ulpi_dir_o))
    else $error("data byte not ended");
  AST_NXT_END: assert property ($rose(ulpi_nxt_o) |-> ##[6:18] !ulpi_nxt_o)
    else $error("nxt stuck");
endmodule // ups_monitor
bind ups_status_power ups_monitor #(.SYNC_W(SYNC_W)) ups_monitor_inst (.ref_clk_i, .rst_b_i,
  .vbus_drive_req_i, .ulpi_data_oe_b_o, .ulpi_dir_o, .ulpi_nxt_o, .power_switch_low_o,
  .power_switch_low_oe_b_o, .pin_reset_req_o);
`default_nettype wire

// ---- verification/ups_link_mdl.sv ----
`timescale 1ns/1ns
`default_nettype none
module ups_link_mdl (
  input wire logic ref_clk_i,
  input wire logic [7:0] phy_data_i,
  output logic link_clk_o,
  output logic [7:0] link_data_o,
  output logic link_stp_o
);
  // Free running, phase unrelated to ref_clk
  initial begin
    link_clk_o = 0;
    link_data_o = 8'h00;
    link_stp_o = 0;
    #3;
    forever #40 link_clk_o = ~link_clk_o;
  end
  task send(input logic [7:0] d, input logic s);
    @(negedge link_clk_o);
    @(posedge ref_clk_i);
    link_data_o <= d;
    link_stp_o <= s;
  endtask
  task head(input logic [1:0] k, input logic [7:0] a, input logic x);
    send(x ? {k, 6'h2f} : {k, a[5:0]}, 1'b0);
    if (x) send(a, 1'b0);
  endtask
  // callers keep power bits 7..4 at zero
  task wr(input logic [7:0] a, input logic [7:0] d, input logic x);
    head(2'b10, a, x);
    send(d, 1'b0);
    send(8'h00, 1'b1);
    send(8'h00, 1'b0);
  endtask
  // Released bus reads 00h from the PHY, never a stale copy of the last byte
  task rd(input logic [7:0] a, input logic x, output logic [7:0] d);
    head(2'b11, a, x);
    send(8'h00, 1'b0);
    send(8'hff, 1'b0);
    @(posedge link_clk_o);
    @(posedge link_clk_o);
    d = phy_data_i;
    send(8'h00, 1'b0);
  endtask
endmodule // ups_link_mdl
`default_nettype wire

// ---- verification/test_ups_status_power.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_ups_status_power;
  logic clk, rst_b, bses, pull, lp, vreq, lclk, lstp, g;
  logic [3:0] cmp, ren, fen;
  logic [1:0] ln;
  logic [7:0] ldat, v;
  wire logic [7:0] pdat;
  wire logic poe, dir, nxt, psw, psw_oe, preq;
  int n_fail = 0;
  int checks_done = 0;
  ups_status_power ups_status_power_inst (.ref_clk_i(clk), .rst_b_i(rst_b),
    .ulpi_clk_i(lclk), .ulpi_data_i(ldat), .ulpi_stp_i(lstp),
    .session_end_flag_i(cmp[3]), .session_valid_flag_i(cmp[2]),
    .bus_voltage_ok_flag_i(cmp[1]), .host_unplug_detect_i(cmp[0]),
    .session_ok_signal_i(bses), .line_level_bit0_i(ln[0]), .line_level_bit1_i(ln[1]),
    .power_switch_low_i(psw_oe & ~pull), .rise_en_i(ren), .fall_en_i(fen),
    .low_power_i(lp), .vbus_drive_req_i(vreq), .ulpi_data_o(pdat),
    .ulpi_data_oe_b_o(poe), .ulpi_dir_o(dir), .ulpi_nxt_o(nxt), .power_switch_low_o(psw),
    .power_switch_low_oe_b_o(psw_oe), .pin_reset_req_o(preq));
  ups_link_mdl ups_link_mdl_inst (.ref_clk_i(clk), .phy_data_i(pdat), .link_clk_o(lclk),
    .link_data_o(ldat), .link_stp_o(lstp));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task final_report;
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task cmp8(input logic [7:0] e, input logic [7:0] a);
    checks_done++;
    if (a !== e) begin
      n_fail++;
      $display("unexpected t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task chk(input logic [7:0] a, input logic x, input logic [7:0] e);
    logic [7:0] r;
    ups_link_mdl_inst.rd(a, x, r);
    cmp8(e, r);
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
  endtask
  // changes reach the link as receive bytes
  task rx;
    g = 0;
    v = 8'h00;
    repeat (48) begin
      @(negedge clk);
      if (poe === 1'b0 && !g) begin
        g = 1;
        v = pdat;
      end
    end
    @(posedge clk);
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Whole sequence needs well under 100 us
  initial begin
    #300000;
    n_fail++;
    final_report;
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst_b = 0;
    cmp = 4'h0;
    bses = 0;
    ln = 2'b10;
    pull = 0;
    ren = 4'hf;
    fen = 4'hf;
    lp = 0;
    vreq = 0;
    step(3);
    rst_b <= 1;
    step(60);
    chk(8'h16, 0, 8'h00);
    chk(8'h3d, 0, 8'h00);
    cmp <= 4'ha;
    step(60);
    chk(8'h14, 0, 8'h0a);
    chk(8'h14, 0, 8'h00);
    chk(8'h13, 0, 8'h0a);
    chk(8'h15, 0, 8'h02);
    ren <= 4'h0;
    cmp <= 4'hf;
    step(60);
    chk(8'h14, 0, 8'h00);
    cmp <= 4'h5;
    ren <= 4'hf;
    step(60);
    chk(8'h14, 0, 8'h0a);
    cmp <= 4'h0;
    step(60);
    lp <= 1;
    step(1);
    lp <= 0;
    chk(8'h14, 0, 8'h00);
    ups_link_mdl_inst.wr(8'h16, 8'ha5, 0);
    ups_link_mdl_inst.wr(8'h17, 8'h0a, 0);
    chk(8'h18, 0, 8'haf);
    ups_link_mdl_inst.wr(8'h18, 8'h21, 0);
    chk(8'h17, 0, 8'h8e);
    ups_link_mdl_inst.wr(8'h20, 8'hff, 0);
    chk(8'h20, 0, 8'h00);
    chk(8'h30, 0, 8'h00);
    chk(8'h16, 0, 8'h8e);
    ups_link_mdl_inst.wr(8'h16, 8'h3c, 1);
    chk(8'h16, 0, 8'h3c);
    chk(8'h16, 1, 8'h3c);
    ups_link_mdl_inst.wr(8'h50, 8'hff, 1);
    chk(8'h50, 1, 8'h00);
    chk(8'h16, 0, 8'h3c);
    ups_link_mdl_inst.wr(8'h3d, 8'h0c, 0);
    ups_link_mdl_inst.wr(8'h3e, 8'h01, 0);
    chk(8'h3d, 0, 8'h0d);
    vreq <= 1;
    step(3);
    cmp8(8'h00, {7'h0, psw_oe});
    ups_link_mdl_inst.wr(8'h3f, 8'h01, 0);
    chk(8'h3d, 0, 8'h0c);
    cmp8(8'h01, {7'h0, psw_oe});
    pull <= 1;
    step(8);
    cmp8(8'h01, {7'h0, preq});
    pull <= 0;
    bses <= 1;
    rx;
    cmp8(8'h81, {v[7], 6'h0, g});
    bses <= 0;
    rx;
    cmp8(8'h81, {v[7], 6'h0, g});
    ups_link_mdl_inst.wr(8'h3d, 8'h00, 0);
    bses <= 1;
    rx;
    cmp8(8'h00, {7'h0, g});
    cmp <= 4'h4;
    step(60);
    chk(8'h13, 0, 8'h04);
    final_report;
  end
endmodule // test_ups_status_power
`default_nettype wire
